// ==== logic/aofr_regs.sv ====
// Operation
// - Output samples are offset binary when format bit is 0, two's complement when 1.
// - Time-stamp capture stays disabled while bit 3 is zero, enabled when set.
// - Offset magnitude applies positive when sign bit is 0, negative when 1.
// - Low twelve trim bits are an unsigned straight-binary offset magnitude.
// - Offset scales linearly, zero at code 0 to 45 mV at 4095.
// - Monotonic response is only guaranteed for the nine top magnitude bits.
// - Offset magnitude resets to zero, meaning no offset, until written.
// - Interleave enable bit zero means normal sampling, one means dual-edge interleaving.
// Register bank for output format, data rate, time stamp, interleave and first channel offset trim.
// Assumes a synchronous register port master with one-cycle strobes and read data one cycle later.
// Derived outputs and the control word are driven from flip-flops.

`include "aofr_consts.svh"
module aofr_regs #(
  parameter int SAMPLE_WIDTH = 12
) (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  input wire logic [SAMPLE_WIDTH-1:0] sample_i,
  input wire logic sample_valid_i,
  output logic [SAMPLE_WIDTH-1:0] sample_o,
  output logic sample_valid_o,
  output logic [SAMPLE_WIDTH:0] offset_code_o,
  output logic [15:0] offset_uv_o,
  output logic [8:0] offset_mono_o,
  output aofr_pkg::aofr_ctrl_t ctrl_o
);
  logic rst_meta_q;
  logic rst_sync_q;
  logic [15:0] main_cfg_q;
  logic [15:0] fixed_pat_q;
  logic [15:0] offs_trim_q;
  logic [15:0] rdata_q;
  logic [SAMPLE_WIDTH-1:0] sample_q;
  logic valid_q;
  logic [11:0] mag;
  logic pol;
  logic [SAMPLE_WIDTH+1:0] sum_d;
  logic [SAMPLE_WIDTH-1:0] sample_d;
  aofr_pkg::aofr_il_mode_t il_mode_d;
  aofr_pkg::aofr_il_mode_t il_mode_q;
  logic cfg_wr_en;
  logic trim_wr_en;
  logic [15:0] cfg_wr_d;
  logic [15:0] trim_wr_d;
  logic [11:0] mag_wr_d;
  logic pol_wr_d;
  logic [SAMPLE_WIDTH:0] offset_code_d;
  logic [15:0] offset_uv_d;
  logic [SAMPLE_WIDTH:0] offset_code_q;
  logic [15:0] offset_uv_q;
  logic [8:0] offset_mono_q;

  // Reset release through two flip-flops.
  // Only the second flip-flop is read, so no register leaves reset on a marginal edge.
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // Write decode; masked values are shared by the registers and by the outputs derived from them.
  assign cfg_wr_en = reg_wr_i && (reg_addr_i == `AOFR_ADDR_MAIN_CFG);
  assign trim_wr_en = reg_wr_i && (reg_addr_i == `AOFR_ADDR_OFFS_TRIM);
  assign cfg_wr_d = (reg_wdata_i & `AOFR_MAIN_CFG_WMASK) | (`AOFR_RST_MAIN_CFG & ~`AOFR_MAIN_CFG_WMASK);
  assign trim_wr_d = reg_wdata_i & `AOFR_OFFS_TRIM_WMASK;
  assign mag_wr_d = trim_wr_d[`AOFR_OFFS_MAG_MSB:0];
  assign pol_wr_d = trim_wr_d[`AOFR_BIT_OFFS_POL];

  // Configuration word; reserved bits keep their default value.
  always_ff @(posedge core_clk_i or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      main_cfg_q <= `AOFR_RST_MAIN_CFG;
    end else if (cfg_wr_en) begin
      main_cfg_q <= cfg_wr_d;
    end
  end

  // Fixed pattern word is stored as written; software must keep the default.
  always_ff @(posedge core_clk_i or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      fixed_pat_q <= `AOFR_RST_FIXED_PAT;
    end else if (reg_wr_i && reg_addr_i == `AOFR_ADDR_FIXED_PAT) begin
      fixed_pat_q <= reg_wdata_i;
    end
  end

  // Offset trim word; the three top bits are held at zero.
  always_ff @(posedge core_clk_i or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      offs_trim_q <= `AOFR_RST_OFFS_TRIM;
    end else if (trim_wr_en) begin
      offs_trim_q <= trim_wr_d;
    end
  end

  // Read data stands in the cycle after the read strobe only.
  always_ff @(posedge core_clk_i or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      rdata_q <= 16'h0000;
    end else if (reg_rd_i) begin
      unique case (reg_addr_i)
        `AOFR_ADDR_MAIN_CFG: rdata_q <= main_cfg_q;
        `AOFR_ADDR_FIXED_PAT: rdata_q <= fixed_pat_q;
        `AOFR_ADDR_OFFS_TRIM: rdata_q <= offs_trim_q;
        default: rdata_q <= 16'h0000;
      endcase
    end else begin
      rdata_q <= 16'h0000;
    end
  end
  assign reg_rdata_o = rdata_q;

  assign mag = offs_trim_q[`AOFR_OFFS_MAG_MSB:0];
  assign pol = offs_trim_q[`AOFR_BIT_OFFS_POL];

  // Interleave mode decode of the value being written to the configuration word.
  always_comb begin
    if (!cfg_wr_d[`AOFR_BIT_INTERLEAVE]) begin
      il_mode_d = aofr_pkg::AOFR_IL_OFF;
    end else if (cfg_wr_d[`AOFR_BIT_IL_JOINED]) begin
      if (cfg_wr_d[`AOFR_BIT_IL_SECOND]) begin
        il_mode_d = aofr_pkg::AOFR_IL_OTHER;
      end else begin
        il_mode_d = aofr_pkg::AOFR_IL_JOINED;
      end
    end else begin
      if (cfg_wr_d[`AOFR_BIT_IL_SECOND]) begin
        il_mode_d = aofr_pkg::AOFR_IL_SECOND;
      end else begin
        il_mode_d = aofr_pkg::AOFR_IL_FIRST;
      end
    end
  end

  // The decoded mode has its own flip-flops so that the control output never glitches.
  always_ff @(posedge core_clk_i or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      il_mode_q <= aofr_pkg::AOFR_IL_OFF;
    end else if (cfg_wr_en) begin
      il_mode_q <= il_mode_d;
    end
  end

  always_comb begin
    ctrl_o.signed_output_format = main_cfg_q[`AOFR_BIT_SIGNED_FMT];
    ctrl_o.timestamp_capture_enable = main_cfg_q[`AOFR_BIT_TSTAMP_EN];
    ctrl_o.single_rate_select = main_cfg_q[`AOFR_BIT_SINGLE_RATE];
    ctrl_o.il_mode = il_mode_q;
    ctrl_o.offset_polarity = pol;
    ctrl_o.offset_trim_magnitude = mag;
  end

  // Signed offset code and its nominal size in microvolts, worked out from the value being written.
  always_comb begin
    if (pol_wr_d) begin
      offset_code_d = (SAMPLE_WIDTH+1)'(-$signed({1'b0, mag_wr_d}));
    end else begin
      offset_code_d = (SAMPLE_WIDTH+1)'({1'b0, mag_wr_d});
    end
    offset_uv_d = 16'((32'(mag_wr_d) * `AOFR_OFFS_FULL_UV) / `AOFR_OFFS_FULL_CODE);
  end

  // The divider sits before a register, so these outputs change on the same edge as the trim word.
  always_ff @(posedge core_clk_i or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      offset_code_q <= '0;
      offset_uv_q <= 16'h0000;
      offset_mono_q <= 9'h000;
    end else if (trim_wr_en) begin
      offset_code_q <= offset_code_d;
      offset_uv_q <= offset_uv_d;
      offset_mono_q <= mag_wr_d[`AOFR_OFFS_MAG_MSB -: `AOFR_OFFS_MONO_BITS];
    end
  end
  assign offset_code_o = offset_code_q;
  assign offset_uv_o = offset_uv_q;
  assign offset_mono_o = offset_mono_q;

  // Offset applied to an offset binary sample with saturation, then format conversion.
  // Saturation keeps a large trim from wrapping a sample round to the opposite end of the scale.
  always_comb begin
    if (pol) begin
      sum_d = {2'b00, sample_i} - (SAMPLE_WIDTH+2)'(mag);
    end else begin
      sum_d = {2'b00, sample_i} + (SAMPLE_WIDTH+2)'(mag);
    end
    if (sum_d[SAMPLE_WIDTH+1]) begin
      sample_d = '0;
    end else if (sum_d[SAMPLE_WIDTH]) begin
      sample_d = '1;
    end else begin
      sample_d = sum_d[SAMPLE_WIDTH-1:0];
    end
    if (main_cfg_q[`AOFR_BIT_SIGNED_FMT]) begin
      sample_d[SAMPLE_WIDTH-1] = ~sample_d[SAMPLE_WIDTH-1];
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      sample_q <= '0;
      valid_q <= 1'b0;
    end else begin
      valid_q <= sample_valid_i;
      if (sample_valid_i) begin
        sample_q <= sample_d;
      end
    end
  end
  assign sample_o = sample_q;
  assign sample_valid_o = valid_q;
endmodule : aofr_regs

// ==== logic/aofr_consts.svh ====
// Register offsets, field positions and reset values of the format and offset register bank.
// Assumes inclusion by bare name from the package and the bank module.
`ifndef AOFR_CONSTS_SVH
`define AOFR_CONSTS_SVH
`define AOFR_ADDR_MAIN_CFG 4'h0
`define AOFR_ADDR_FIXED_PAT 4'h1
`define AOFR_ADDR_OFFS_TRIM 4'h2
`define AOFR_RST_MAIN_CFG 16'h2000
`define AOFR_RST_FIXED_PAT 16'h2907
`define AOFR_RST_OFFS_TRIM 16'h0000
`define AOFR_MAIN_CFG_WMASK 16'hFDFC
`define AOFR_OFFS_TRIM_WMASK 16'h1FFF
`define AOFR_BIT_INTERLEAVE 7
`define AOFR_BIT_IL_SECOND 6
`define AOFR_BIT_IL_JOINED 5
`define AOFR_BIT_SIGNED_FMT 4
`define AOFR_BIT_TSTAMP_EN 3
`define AOFR_BIT_SINGLE_RATE 2
`define AOFR_BIT_OFFS_POL 12
`define AOFR_OFFS_MAG_MSB 11
`define AOFR_OFFS_MAG_WIDTH 12
`define AOFR_OFFS_MONO_BITS 9
`define AOFR_OFFS_FULL_UV 45000
`define AOFR_OFFS_FULL_CODE 4095
`endif

// ==== logic/aofr_pkg.sv ====
// Types shared by the format and offset register bank.
// Assumes the constants header is on the include path.
`include "aofr_consts.svh"
package aofr_pkg;
  typedef enum logic [2:0] {
    AOFR_IL_OFF,
    AOFR_IL_FIRST,
    AOFR_IL_SECOND,
    AOFR_IL_JOINED,
    AOFR_IL_OTHER
  } aofr_il_mode_t;

  typedef struct packed {
    logic signed_output_format;
    logic timestamp_capture_enable;
    logic single_rate_select;
    aofr_il_mode_t il_mode;
    logic offset_polarity;
    logic [11:0] offset_trim_magnitude;
  } aofr_ctrl_t;
endpackage : aofr_pkg

// ==== test/aofr_regs_monitor.sv ====
// Concurrent checks on the register bank ports.
// Assumes the default sample width of twelve bits.
module aofr_regs_monitor (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic [11:0] sample_i,
  input wire logic [11:0] sample_o,
  input wire logic sample_valid_o,
  input wire logic [12:0] offset_code_o,
  input wire logic [15:0] offset_uv_o,
  input wire aofr_pkg::aofr_ctrl_t ctrl_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  sequence s_cfg_wr; reg_wr_i && reg_addr_i == 4'h0; endsequence
  sequence s_trim_wr; reg_wr_i && reg_addr_i == 4'h2; endsequence
  property p_fmt; sample_valid_o && $past(ctrl_o.offset_trim_magnitude) == 12'h000 |->
    sample_o == {$past(sample_i[11]) ^ $past(ctrl_o.signed_output_format), $past(sample_i[10:0])}; endproperty
  a_fmt: assert property (p_fmt) else $error("format");
  property p_ts; s_cfg_wr |=> ctrl_o.timestamp_capture_enable == $past(reg_wdata_i[3]); endproperty
  a_ts: assert property (p_ts) else $error("stamp");
  property p_rate; s_cfg_wr |=> ctrl_o.single_rate_select == $past(reg_wdata_i[2]); endproperty
  a_rate: assert property (p_rate) else $error("rate");
  property p_fix; reg_rd_i && reg_addr_i == 4'h1 |=> reg_rdata_o == 16'h2907; endproperty
  a_fix: assert property (p_fix) else $error("fixed");
  property p_sign; offset_code_o == (ctrl_o.offset_polarity ? 13'h0000 - {1'b0, ctrl_o.offset_trim_magnitude}
    : {1'b0, ctrl_o.offset_trim_magnitude}); endproperty
  a_sign: assert property (p_sign) else $error("sign");
  property p_mag; s_trim_wr |=> ctrl_o.offset_trim_magnitude == $past(reg_wdata_i[11:0]); endproperty
  a_mag: assert property (p_mag) else $error("magnitude");
  property p_uv; offset_uv_o == 16'((32'(ctrl_o.offset_trim_magnitude) * 45000) / 4095); endproperty
  a_uv: assert property (p_uv) else $error("scale");
  property p_il; s_cfg_wr ##0 !reg_wdata_i[7] |=> ctrl_o.il_mode == aofr_pkg::AOFR_IL_OFF; endproperty
  a_il: assert property (p_il) else $error("interleave");
endmodule : aofr_regs_monitor
bind aofr_regs aofr_regs_monitor aofr_regs_monitor_inst (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .sample_i(sample_i), .sample_o(sample_o), .sample_valid_o(sample_valid_o),
  .offset_code_o(offset_code_o), .offset_uv_o(offset_uv_o), .ctrl_o(ctrl_o));

// ==== test/tb.sv ====
// Self-checking bench for the register bank.
// Assumes the bank and its checker are compiled first.
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, nrst, wr, rd, sv, svo;
  logic [3:0] addr;
  logic [15:0] wd, rdata, ouv;
  logic [11:0] si, so;
  logic [12:0] oc;
  logic [8:0] om;
  aofr_pkg::aofr_ctrl_t ctrl;
  int n_errors = 0;
  int n_tests = 0;
  aofr_regs aofr_regs_inst (.core_clk_i(clk), .nrst_i(nrst), .reg_addr_i(addr), .reg_wdata_i(wd),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .sample_i(si), .sample_valid_i(sv), .sample_o(so),
    .sample_valid_o(svo), .offset_code_o(oc), .offset_uv_o(ouv), .offset_mono_o(om), .ctrl_o(ctrl));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wrr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(negedge clk);
  endtask : wrr
  task automatic rdr(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(rdata, e);
  endtask : rdr
  task automatic smp(input logic [11:0] d, input logic [11:0] e);
    @(posedge clk);
    si <= d;
    sv <= 1'b1;
    @(posedge clk);
    sv <= 1'b0;
    @(negedge clk);
    chk({4'h0, so}, {4'h0, e});
    chk({15'h0000, svo}, 16'h0001);
  endtask : smp
  task automatic tally_and_finish;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    {nrst, wr, rd, sv, addr, wd, si} = '0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    rdr(4'h0, 16'h2000);
    rdr(4'h1, 16'h2907);
    rdr(4'h2, 16'h0000);
    rdr(4'h5, 16'h0000);
    chk({3'b000, oc}, 16'h0000);
    smp(12'h123, 12'h123);
    $display("reset test done");
    wrr(4'h1, 16'h2907);
    rdr(4'h1, 16'h2907);
    wrr(4'h0, 16'hFFFF);
    rdr(4'h0, 16'hFDFC);
    chk({13'h0, ctrl.signed_output_format, ctrl.timestamp_capture_enable, ctrl.single_rate_select}, 16'h0007);
    chk({13'h0, ctrl.il_mode}, {13'h0, aofr_pkg::AOFR_IL_OTHER});
    wrr(4'h0, 16'h0080);
    chk({13'h0, ctrl.il_mode}, {13'h0, aofr_pkg::AOFR_IL_FIRST});
    wrr(4'h0, 16'h00C0);
    chk({13'h0, ctrl.il_mode}, {13'h0, aofr_pkg::AOFR_IL_SECOND});
    wrr(4'h0, 16'h00A0);
    chk({13'h0, ctrl.il_mode}, {13'h0, aofr_pkg::AOFR_IL_JOINED});
    wrr(4'h0, 16'h0000);
    chk({13'h0, ctrl.il_mode}, {13'h0, aofr_pkg::AOFR_IL_OFF});
    chk({13'h0, ctrl.signed_output_format, ctrl.timestamp_capture_enable, ctrl.single_rate_select}, 16'h0000);
    $display("config test done");
    wrr(4'h2, 16'h1010);
    rdr(4'h2, 16'h1010);
    chk({3'b000, oc}, 16'h1FF0);
    smp(12'h800, 12'h7F0);
    wrr(4'h0, 16'h0010);
    smp(12'h800, 12'hFF0);
    wrr(4'h0, 16'h0000);
    wrr(4'h2, 16'h0FFF);
    chk(ouv, 16'hAFC8);
    chk({7'h00, om}, 16'h01FF);
    smp(12'hFFF, 12'hFFF);
    chk({3'b000, oc}, 16'h0FFF);
    $display("offset test done");
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    rdr(4'h2, 16'h0000);
    chk(ouv, 16'h0000);
    wrr(4'h0, 16'h0010);
    smp(12'h123, 12'h923);
    $display("restart test done");
    tally_and_finish();
  end
endmodule : tb
